/* File: dv/sacc_props.sv */
// Concurrent checks on the start and busy link between host and converter.
`timescale 1ns/100ps
`default_nettype none
module sacc_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Link signals.
  input wire logic conversion_start_n,
  input wire logic busy
);
  // Power-up pulse and conversion lengths in clock cycles.
  localparam int PULSE = sacc_pkg::PWRUP_CYCLES;
  localparam int CONV = sacc_pkg::CONV_CYCLES;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic start_q_reg; // Start level seen at the last edge.
  logic armed_reg; // A start fall has come since busy was last high.
  logic [9:0] since_reg; // Cycles since a start rise, all ones if none.
  logic [9:0] busy_cnt_reg; // Cycles that busy has stood high.

  // Helper counters. Reset clears them, so a run after a second reset
  // cannot lean on a start edge from before it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      start_q_reg <= 1'b0;
      armed_reg <= 1'b0;
      since_reg <= 10'h3ff;
      busy_cnt_reg <= 10'h000;
    end else begin
      start_q_reg <= conversion_start_n;
      // A fall during a conversion must not arm the next one.
      armed_reg <= busy ? 1'b0 :
                   ((start_q_reg && !conversion_start_n) ? 1'b1 : armed_reg);
      if (conversion_start_n && !start_q_reg) begin
        since_reg <= 10'h000;
      end else if (since_reg < 10'h3fe) begin
        // Stops at 3fe, so a long high-speed gap never reads as none.
        since_reg <= since_reg + 10'h001;
      end
      busy_cnt_reg <= busy ? busy_cnt_reg + 10'h001 : 10'h000;
    end
  end

  //----------------------------------------------------------------------------
  // Conversion steps.
  //----------------------------------------------------------------------------
  sequence s_conv_begin;
    $rose(busy);
  endsequence
  sequence s_conv_end;
    $fell(busy);
  endsequence

  chk_busy_holds: assert property (s_conv_begin |-> busy[*8])
    else $error("busy dropped early");
  chk_conv_length: assert property (
    s_conv_end |-> busy_cnt_reg == CONV)
    else $error("conversion length wrong");
  chk_busy_bound: assert property (busy_cnt_reg <= CONV)
    else $error("busy stayed high too long");
  chk_start_low: assert property (
    s_conv_begin |-> !$past(conversion_start_n) &&
                     !$past(conversion_start_n, 2))
    else $error("conversion began with start high");
  chk_pulse_first: assert property (
    s_conv_begin |-> since_reg >= PULSE && since_reg != 10'h3ff)
    else $error("conversion before power-up pulse ended");
  chk_start_armed: assert property (s_conv_begin |-> armed_reg)
    else $error("conversion without a start fall");
  chk_reset_idle: assert property ($rose(reset_n) |-> !busy[*8])
    else $error("busy after reset");
  chk_acq_quiet: assert property (s_conv_end |-> !busy[*4])
    else $error("no acquisition gap");
  chk_acq_gap: assert property (
    s_conv_end |-> (!$fell(conversion_start_n))[*4])
    else $error("start fell inside acquisition");
  chk_reset_start: assert property (
    $rose(reset_n) |-> !conversion_start_n)
    else $error("start high at power-on");
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench joining the host and converter ends.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk; // 40 MHz clock.
  logic reset_n; // Synchronous reset, active low.
  logic req; // Conversion request to the host.
  logic power_down_mode; // Mode asked with the request.
  logic [sacc_pkg::CNT_W-1:0] pulse_cycles; // Start pulse length.
  logic [sacc_pkg::DATA_W-1:0] sample_code; // Digitised input.
  logic [sacc_pkg::DATA_W-1:0] result; // Converter result.
  logic powered; // Converter status outputs.
  logic tracking;
  logic mode_power_down;
  logic ready; // Host status outputs.
  logic done;
  int errors; // Mismatches seen.
  int num_checks; // Comparisons made.
  int k; // Loop index for random runs.
  logic asleep; // Converter expected asleep, with start low.

  sacc_link_if link ();
  sacc_device u_sacc_device (.clk(clk), .reset_n(reset_n), .link(link),
    .sample_code(sample_code), .result(result), .powered(powered),
    .tracking(tracking), .mode_power_down(mode_power_down));
  sacc_host u_sacc_host (.clk(clk), .reset_n(reset_n), .link(link),
    .req(req), .power_down_mode(power_down_mode),
    .pulse_cycles(pulse_cycles), .ready(ready), .done(done));
  sacc_props u_sacc_props (.clk(clk), .reset_n(reset_n),
    .conversion_start_n(link.conversion_start_n), .busy(link.busy));

  // Free-running clock, 25 ns period.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  //----------------------------------------------------------------------------
  // Compare and report.
  //----------------------------------------------------------------------------
  task automatic cmp_eq(input logic [9:0] got, input logic [9:0] exp,
                        input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_range(input int got, input int lo, input int hi,
                           input string what);
    num_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("wrong value at %0t: %s %0d", $time, what, got);
    end
  endtask

  task automatic print_verdict;
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A wait that runs out is a mismatch and ends the run.
  task automatic hang(input string what);
    errors++;
    $display("wrong value at %0t: no %s", $time, what);
    print_verdict();
  endtask

  // Cycles from request to busy. A rising start wakes the converter and
  // fires the power-up pulse, so the longer of the two counts; a start
  // left high by a high-speed conversion gives no new pulse.
  function automatic int exp_gate(input int pc, input logic woke);
    int p;
    p = (pc == 0) ? 1 : pc;
    if (!woke) return p;
    return (p > sacc_pkg::PWRUP_CYCLES) ? p : sacc_pkg::PWRUP_CYCLES;
  endfunction

  // Holds reset for 12 cycles, then checks the power-on state.
  task automatic apply_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    asleep = 1'b1;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    cmp_eq(powered, 1'b0, "powered");
    cmp_eq(link.busy, 1'b0, "busy");
    cmp_eq(result, sacc_pkg::RESULT_RST, "result");
    cmp_eq(tracking, 1'b0, "tracking");
  endtask

  // One full conversion; sample_code is held until the next request.
  task automatic convert(input logic pd, input logic [9:0] pc,
                         input logic [7:0] code);
    int i;
    int n_pre;
    int n_busy;
    int gate;
    int n_conv;
    n_pre = 0;
    n_busy = 0;
    gate = exp_gate(pc, asleep);
    n_conv = sacc_pkg::CONV_CYCLES;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      #1;
      if (ready === 1'b1) break;
    end
    if (i == 100) hang("ready");
    // Ready was seen settled; the request goes out on the next edge.
    @(posedge clk);
    req <= 1'b1;
    power_down_mode <= pd;
    pulse_cycles <= pc;
    sample_code <= code;
    @(posedge clk);
    req <= 1'b0;
    for (i = 0; i < 2000 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (link.busy === 1'b1) n_busy++;
      else if (n_busy == 0) n_pre++;
    end
    if (i == 2000) hang("done");
    cmp_range(n_pre, gate, gate + 10, "gate");
    cmp_range(n_busy, n_conv, n_conv, "busy length");
    cmp_eq(result, code, "result");
    cmp_eq(mode_power_down, pd, "mode");
    cmp_eq(powered, !pd, "powered");
    cmp_eq(tracking, !pd, "tracking");
    // Power-down mode leaves start low, so the next request wakes it.
    asleep = pd;
  endtask

  // Main sequence: corners first, then random conversions around a reset.
  initial begin
    errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    req = 1'b0;
    power_down_mode = 1'b0;
    pulse_cycles = 10'h001;
    sample_code = 8'h00;
    void'($urandom(96));
    apply_reset();
    // Shortest pulse, pulse equal to power-up, longer pulse, zero count.
    convert(1'b1, 10'h001, 8'h00);
    convert(1'b0, 10'h03c, 8'hff);
    convert(1'b0, 10'h064, 8'h5a);
    convert(1'b1, 10'h000, 8'h80);
    for (k = 0; k < 12; k++) begin
      if (k == 6) apply_reset();
      convert(1'($urandom_range(1, 0)), 10'($urandom_range(100, 1)),
              8'($urandom()));
    end
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: hw/sacc_device.sv */
// Converter end: power sequencing, conversion timing, busy and result.
`timescale 1ns/100ps
`default_nettype none
module sacc_device (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Link to the host.
  sacc_link_if.dev link,
  // Sampled analog value, already digitised, from the front end.
  input wire logic [sacc_pkg::DATA_W-1:0] sample_code,
  // Result register and status.
  output logic [sacc_pkg::DATA_W-1:0] result,
  output logic powered,
  output logic tracking,
  output logic mode_power_down
);

  //----------------------------------------------------------------------------
  // Pin synchroniser
  //----------------------------------------------------------------------------

  // Two stages; only the second stage feeds logic.
  logic start_meta_reg;
  logic start_sync_reg;
  logic start_prev_reg;

  // The pin is treated as foreign even when the host shares this clock:
  // the host may sit on another board, and a clean level is worth two
  // cycles of latency. The price is that a start pulse must stand for
  // at least one clock to be seen at all. Reset clears all three stages
  // to the low level the pin must have at power-on, so no false rise.
  // The start pin comes from another party, so it is synchronised first.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      start_meta_reg <= 1'b0;
      start_sync_reg <= 1'b0;
      start_prev_reg <= 1'b0;
    end else begin
      start_meta_reg <= link.conversion_start_n;
      start_sync_reg <= start_meta_reg;
      start_prev_reg <= start_sync_reg;
    end
  end

  // Edge of the external start.
  logic start_rise;
  assign start_rise = start_sync_reg && !start_prev_reg;

  //----------------------------------------------------------------------------
  // Power-up pulse and gated start
  //----------------------------------------------------------------------------

  // Internal power-up pulse.
  logic pwrup_pulse;

  // The timer is retriggered by every rise, even during a conversion.
  // That is harmless: busy is decided by the conversion counter alone,
  // and the pulse has ended long before the next acquisition window.
  // Each rising start edge retriggers the power-up pulse.
  sacc_pulse_timer #(
    .CYCLES(sacc_pkg::PWRUP_CYCLES)
  ) u_pwrup (
    .clk(clk),
    .reset_n(reset_n),
    .trigger(start_rise),
    .pulse(pwrup_pulse)
  );

  // Both inputs of the OR come from flip-flops on this clock, so the
  // gated start cannot glitch between edges.
  // Gated start and its previous value.
  logic gated;
  logic gated_prev_reg;
  assign gated = start_sync_reg | pwrup_pulse;

  // Track the gated signal for edge detection.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gated_prev_reg <= 1'b0;
    end else begin
      gated_prev_reg <= gated;
    end
  end

  // Falling edge of the gated start; the later of the two falls counts.
  logic gated_fall;
  assign gated_fall = gated_prev_reg && !gated;

  //----------------------------------------------------------------------------
  // Conversion state machine
  //----------------------------------------------------------------------------

  // State, timer, result and mode.
  sacc_pkg::sacc_state_t state_reg;
  sacc_pkg::sacc_state_t state_next;
  logic [sacc_pkg::CNT_W-1:0] conv_cnt_reg;
  logic [sacc_pkg::CNT_W-1:0] conv_cnt_next;
  logic [sacc_pkg::DATA_W-1:0] hold_reg;
  logic [sacc_pkg::DATA_W-1:0] hold_next;
  logic [sacc_pkg::DATA_W-1:0] result_reg;
  logic [sacc_pkg::DATA_W-1:0] result_next;
  logic busy_reg;
  logic busy_next;
  logic mode_pd_reg;
  logic mode_pd_next;

  // How one conversion runs, counted in clock edges from the pin:
  // - The pin is two flops behind the host, so a rise is seen on the
  //   third edge after the pin moves.
  // - Asleep, that rise wakes the converter and reloads the pulse
  //   timer; the gated start then stays high for at least the pulse.
  // - The later of the two falls, pin or pulse, takes the sample into
  //   hold and raises busy on the next edge.
  // - Busy stands for the conversion count, then falls on the edge that
  //   loads the result and picks the mode from the pin level.
  // A gated fall while asleep or converting is ignored: asleep there is
  // no powered front end to hold, and a second fall mid-conversion would
  // spoil the value already in hold.
  // Next-state logic.
  always_comb begin
    state_next = state_reg;
    conv_cnt_next = conv_cnt_reg;
    hold_next = hold_reg;
    result_next = result_reg;
    busy_next = busy_reg;
    mode_pd_next = mode_pd_reg;
    case (state_reg)
      sacc_pkg::SACC_POWER_DOWN: begin
        // Asleep until a rising start edge wakes the converter.
        if (start_rise) begin
          state_next = sacc_pkg::SACC_POWERED;
        end
      end
      sacc_pkg::SACC_POWERED: begin
        // Tracking; the gated falling edge takes the sample into hold.
        if (gated_fall) begin
          state_next = sacc_pkg::SACC_CONVERTING;
          hold_next = sample_code;
          conv_cnt_next = sacc_pkg::CNT_W'(sacc_pkg::CONV_CYCLES);
          busy_next = 1'b1;
        end
      end
      sacc_pkg::SACC_CONVERTING: begin
        // Count down; the sample in hold is not touched meanwhile.
        if (conv_cnt_reg > sacc_pkg::CNT_W'(1)) begin
          conv_cnt_next = conv_cnt_reg - 1'b1;
        end else begin
          // End of conversion: latch, drop busy, choose the mode.
          conv_cnt_next = '0;
          busy_next = 1'b0;
          result_next = hold_reg;
          mode_pd_next = !start_sync_reg;
          if (start_sync_reg) begin
            // Pin high at the end: high-speed mode, stay awake.
            state_next = sacc_pkg::SACC_POWERED;
          end else begin
            // Pin low at the end: automatic power-down.
            state_next = sacc_pkg::SACC_POWER_DOWN;
          end
        end
      end
      default: begin
        // An illegal code falls back to the safe sleeping state.
        state_next = sacc_pkg::SACC_POWER_DOWN;
      end
    endcase
  end

  // The mode flag comes up as power-down so that status agrees with the
  // sleeping state until the first conversion has picked a mode of its
  // own.
  // State registers; reset stands for power first applied.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= sacc_pkg::SACC_POWER_DOWN;
      conv_cnt_reg <= '0;
      hold_reg <= sacc_pkg::RESULT_RST;
      result_reg <= sacc_pkg::RESULT_RST;
      busy_reg <= 1'b0;
      mode_pd_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      conv_cnt_reg <= conv_cnt_next;
      hold_reg <= hold_next;
      result_reg <= result_next;
      busy_reg <= busy_next;
      mode_pd_reg <= mode_pd_next;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------

  // Limitation: the result has no read strobe here; it simply holds from
  // one end of conversion to the next, so a host that reads late sees
  // the newest code, never a half-built one.
  // Busy and data come straight from flip-flops.
  assign link.busy = busy_reg;
  assign result = result_reg;
  assign mode_power_down = mode_pd_reg;
  assign powered = (state_reg != sacc_pkg::SACC_POWER_DOWN);
  // The sampler tracks whenever it is powered and not converting.
  assign tracking = (state_reg == sacc_pkg::SACC_POWERED);

endmodule
`default_nettype wire

/* File: hw/sacc_host.sv */
// Host end: issues start pulses and collects end-of-conversion events.
`timescale 1ns/100ps
`default_nettype none
module sacc_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Link to the converter.
  sacc_link_if.host link,
  // User request side.
  input wire logic req,
  input wire logic power_down_mode,
  input wire logic [sacc_pkg::CNT_W-1:0] pulse_cycles,
  output logic ready,
  output logic done
);

  // Busy synchroniser; only the second stage feeds logic.
  logic busy_meta_reg;
  logic busy_sync_reg;
  logic busy_prev_reg;

  // Register the pin through two stages plus an edge stage.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_meta_reg <= 1'b0;
      busy_sync_reg <= 1'b0;
      busy_prev_reg <= 1'b0;
    end else begin
      busy_meta_reg <= link.busy;
      busy_sync_reg <= busy_meta_reg;
      busy_prev_reg <= busy_sync_reg;
    end
  end

  // State, counter, start pin and mode.
  sacc_pkg::sacc_host_state_t state_reg;
  sacc_pkg::sacc_host_state_t state_next;
  logic [sacc_pkg::CNT_W-1:0] cnt_reg;
  logic [sacc_pkg::CNT_W-1:0] cnt_next;
  logic start_reg;
  logic start_next;
  logic pd_reg;
  logic pd_next;
  logic done_next;
  logic done_reg;

  // Sequencer: high pulse, fall, wait for busy, then acquisition gap.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    start_next = start_reg;
    pd_next = pd_reg;
    done_next = 1'b0;
    case (state_reg)
      sacc_pkg::SACC_H_IDLE: begin
        if (req) begin
          // Short pulse keeps power low in power-down mode.
          state_next = sacc_pkg::SACC_H_PULSE;
          start_next = 1'b1;
          pd_next = power_down_mode;
          cnt_next = (pulse_cycles == '0) ? sacc_pkg::CNT_W'(1) : pulse_cycles;
        end
      end
      sacc_pkg::SACC_H_PULSE: begin
        if (cnt_reg > sacc_pkg::CNT_W'(1)) begin
          cnt_next = cnt_reg - 1'b1;
        end else begin
          start_next = 1'b0;
          state_next = sacc_pkg::SACC_H_WAIT_BUSY;
        end
      end
      sacc_pkg::SACC_H_WAIT_BUSY: begin
        if (busy_sync_reg) begin
          // High speed mode raises start again before busy falls.
          start_next = !pd_reg;
          state_next = sacc_pkg::SACC_H_WAIT_DONE;
        end
      end
      sacc_pkg::SACC_H_WAIT_DONE: begin
        if (busy_prev_reg && !busy_sync_reg) begin
          done_next = 1'b1;
          cnt_next = sacc_pkg::CNT_W'(sacc_pkg::ACQ_CYCLES);
          state_next = sacc_pkg::SACC_H_ACQ;
        end
      end
      sacc_pkg::SACC_H_ACQ: begin
        // Acquisition time passes before another start falls.
        if (cnt_reg > sacc_pkg::CNT_W'(1)) begin
          cnt_next = cnt_reg - 1'b1;
        end else begin
          // Start keeps its level. In high-speed mode a fall here would
          // begin a conversion that no request asked for, and its end
          // would then be paired with the next request by mistake.
          state_next = sacc_pkg::SACC_H_IDLE;
        end
      end
      default: begin
        state_next = sacc_pkg::SACC_H_IDLE;
      end
    endcase
  end

  // Registers; start held low from reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= sacc_pkg::SACC_H_IDLE;
      cnt_reg <= '0;
      start_reg <= 1'b0;
      pd_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      start_reg <= start_next;
      pd_reg <= pd_next;
      done_reg <= done_next;
    end
  end

  // Outputs.
  assign link.conversion_start_n = start_reg;
  assign ready = (state_reg == sacc_pkg::SACC_H_IDLE);
  assign done = done_reg;

endmodule
`default_nettype wire

/* File: hw/sacc_link_if.sv */
// Interface joining the converter's start and busy pins to the host.
`timescale 1ns/100ps
`default_nettype none
interface sacc_link_if;
  // Conversion start, driven by the host, active low.
  logic conversion_start_n;
  // Busy, driven by the converter, high during conversion.
  logic busy;

  // Converter end.
  modport dev (
    input conversion_start_n,
    output busy
  );

  // Host end.
  modport host (
    output conversion_start_n,
    input busy
  );
endinterface
`default_nettype wire

/* File: hw/sacc_pkg.sv */
// Package of constants and types shared by the converter control and host ends.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sacc_pkg;

  // Clock period in picoseconds (40 MHz).
  localparam int CLK_PERIOD_PS = 25000;

  // Power-up pulse length in nanoseconds, and its cycle count.
  localparam int PWRUP_TIME_NS = 1500;
  localparam int PWRUP_CYCLES = (PWRUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;

  // Conversion time in nanoseconds, and its cycle count.
  localparam int CONV_TIME_NS = 4500;
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;

  // Least acquisition time in nanoseconds, and its cycle count.
  localparam int ACQ_TIME_NS = 100;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;

  // Width of result and of the interval counters.
  localparam int DATA_W = 8;
  localparam int CNT_W = 10;

  // Reset value of the result register.
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;

  // Converter states.
  typedef enum logic [1:0] {
    SACC_POWER_DOWN,
    SACC_POWERED,
    SACC_CONVERTING
  } sacc_state_t;

  // Host sequencer states.
  typedef enum logic [2:0] {
    SACC_H_IDLE,
    SACC_H_PULSE,
    SACC_H_WAIT_BUSY,
    SACC_H_WAIT_DONE,
    SACC_H_ACQ
  } sacc_host_state_t;

endpackage

/* File: hw/sacc_pulse_timer.sv */
// Retriggerable one-shot that holds its output high for a set cycle count.
`timescale 1ns/100ps
`default_nettype none
module sacc_pulse_timer #(
  parameter int CYCLES = sacc_pkg::PWRUP_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Trigger and pulse.
  input wire logic trigger,
  output logic pulse
);

  // Down counter; nonzero while the pulse stands.
  logic [sacc_pkg::CNT_W-1:0] count_reg;
  logic [sacc_pkg::CNT_W-1:0] count_next;

  // Reload on a trigger, otherwise count down to zero.
  always_comb begin
    count_next = count_reg;
    if (trigger) begin
      count_next = sacc_pkg::CNT_W'(CYCLES);
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Register the count.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // The pulse goes high on the edge after the trigger and stays high for CYCLES cycles.
  assign pulse = (count_reg != '0);

endmodule
`default_nettype wire
